// File: hdl/gcb_top.v
// Overhead byte channel adaptation: client to path source and path to client sink
`timescale 1ns/1ps
`include "gcb_regs.vh"
module gcb_top (
  input  wire       core_clk_i,
  input  wire       reset_n_i,
  // Source, client side
  input  wire       client_channel_data_i,
  input  wire       client_channel_clock_i,
  input  wire       client_octet_phase_i,
  // Source, path side
  input  wire       path_timing_clock_i,
  input  wire       path_frame_start_i,
  input  wire       src_function_activate_i,
  output wire [7:0] path_frame_data_o,
  output wire       path_gc_write_o,
  output wire       src_slip_pos_o,
  output wire       src_slip_neg_o,
  // Sink, path side
  input  wire [7:0] rx_path_frame_data_i,
  input  wire       rx_path_clock_i,
  input  wire       rx_gc_strobe_i,
  input  wire       trail_signal_fail_in_i,
  input  wire       snk_function_activate_i,
  // Sink, client side
  output wire       snk_client_data_o,
  output wire       snk_client_clock_o,
  output wire       snk_octet_phase_o,
  output wire       alarm_substitute_action_o
);

  localparam [2:0] ST_IDLE = 3'b001;
  localparam [2:0] ST_SKIP = 3'b010;
  localparam [2:0] ST_TAKE = 3'b100;

  // ---------------- Source: client octet assembly ----------------
  reg        cli_clk_d_r;
  reg [7:0]  asm_shift_r;
  reg [3:0]  asm_cnt_r;
  reg [7:0]  asm_octet_r;
  reg        asm_valid_r;
  wire       cli_rise;
  wire       fifo_in_ready;

  assign cli_rise = client_channel_clock_i & ~cli_clk_d_r;

  always @(posedge core_clk_i) begin
    if (!reset_n_i) begin
      cli_clk_d_r <= 1'b0;
      asm_shift_r <= 8'h00;
      asm_cnt_r   <= 4'h0;
      asm_octet_r <= 8'h00;
      asm_valid_r <= 1'b0;
    end else begin
      cli_clk_d_r <= client_channel_clock_i;
      if (asm_valid_r && fifo_in_ready) begin
        asm_valid_r <= 1'b0;
      end
      if (cli_rise) begin
        asm_shift_r <= {asm_shift_r[6:0], client_channel_data_i};
        if (client_octet_phase_i) begin
          asm_cnt_r <= 4'h1;
        end else if (asm_cnt_r == `GCB_OCTET_LAST) begin
          asm_cnt_r <= 4'h1;
        end else begin
          asm_cnt_r <= asm_cnt_r + 4'h1;
        end
        // A full octet is handed to the buffer, held while it is stalled
        if ((asm_cnt_r == 4'h7) && !client_octet_phase_i) begin
          asm_octet_r <= {asm_shift_r[6:0], client_channel_data_i};
          asm_valid_r <= 1'b1;
        end
      end
    end
  end

  // ---------------- Source: slip buffer ----------------
  wire [7:0] fifo_out_data;
  wire       fifo_out_valid;
  wire [5:0] fifo_level;
  reg        fifo_pop;

  gcb_fifo #(
    .WIDTH (`GCB_OCTET_W),
    .DEPTH (`GCB_FIFO_DEPTH),
    .AW    (`GCB_FIFO_AW)
  ) u_slip_fifo (
    .core_clk_i  (core_clk_i),
    .reset_n_i   (reset_n_i),
    .in_data_i   (asm_octet_r),
    .in_valid_i  (asm_valid_r),
    .in_ready_o  (fifo_in_ready),
    .out_data_o  (fifo_out_data),
    .out_valid_o (fifo_out_valid),
    .out_ready_i (fifo_pop),
    .level_o     (fifo_level)
  );

  // ---------------- Source: read-out on path frame ----------------
  reg        path_clk_d_r;
  reg [2:0]  rd_state_r;
  reg [2:0]  rd_state_nxt;
  reg [7:0]  gc_data_r;
  reg [7:0]  gc_data_nxt;
  reg        gc_write_r;
  reg        gc_write_nxt;
  reg        slip_pos_r;
  reg        slip_pos_nxt;
  reg        slip_neg_r;
  reg        slip_neg_nxt;
  wire       frame_tick;
  wire       near_full;
  wire       near_empty;

  assign frame_tick = path_timing_clock_i & ~path_clk_d_r & path_frame_start_i;
  assign near_full  = (fifo_level >= `GCB_FILL_HIGH);
  assign near_empty = (fifo_level <= `GCB_FILL_LOW) || !fifo_out_valid;

  always @* begin
    rd_state_nxt = rd_state_r;
    gc_data_nxt  = gc_data_r;
    gc_write_nxt = 1'b0;
    slip_pos_nxt = 1'b0;
    slip_neg_nxt = 1'b0;
    fifo_pop     = 1'b0;
    case (rd_state_r)
      ST_IDLE: begin
        if (frame_tick) begin
          if (near_full) begin
            // Head octet is dropped; the next one fills this frame
            fifo_pop     = 1'b1;
            slip_pos_nxt = 1'b1;
            rd_state_nxt = ST_SKIP;
          end else if (near_empty) begin
            gc_write_nxt = src_function_activate_i;
            slip_neg_nxt = 1'b1;
          end else begin
            fifo_pop     = 1'b1;
            gc_data_nxt  = fifo_out_data;
            gc_write_nxt = src_function_activate_i;
          end
        end
      end
      ST_SKIP: begin
        rd_state_nxt = ST_TAKE;
      end
      ST_TAKE: begin
        rd_state_nxt = ST_IDLE;
        gc_write_nxt = src_function_activate_i;
        if (fifo_out_valid) begin
          fifo_pop    = 1'b1;
          gc_data_nxt = fifo_out_data;
        end
      end
      default: begin
        rd_state_nxt = ST_IDLE;
      end
    endcase
  end

  always @(posedge core_clk_i) begin
    if (!reset_n_i) begin
      path_clk_d_r <= 1'b0;
      rd_state_r   <= ST_IDLE;
      gc_data_r    <= `GCB_ALL_ONES;
      gc_write_r   <= 1'b0;
      slip_pos_r   <= 1'b0;
      slip_neg_r   <= 1'b0;
    end else begin
      path_clk_d_r <= path_timing_clock_i;
      rd_state_r   <= rd_state_nxt;
      gc_data_r    <= gc_data_nxt;
      gc_write_r   <= gc_write_nxt;
      slip_pos_r   <= slip_pos_nxt;
      slip_neg_r   <= slip_neg_nxt;
    end
  end

  assign path_frame_data_o = gc_data_r;
  assign path_gc_write_o   = gc_write_r;
  assign src_slip_pos_o    = slip_pos_r;
  assign src_slip_neg_o    = slip_neg_r;

  // ---------------- Sink: overhead byte latch ----------------
  reg        rx_clk_d_r;
  reg [7:0]  store_r;
  wire       rx_rise;

  assign rx_rise = rx_path_clock_i & ~rx_clk_d_r;

  always @(posedge core_clk_i) begin
    if (!reset_n_i) begin
      rx_clk_d_r <= 1'b0;
      store_r    <= `GCB_ALL_ONES;
    end else begin
      rx_clk_d_r <= rx_path_clock_i;
      if (rx_rise && rx_gc_strobe_i) begin
        store_r <= rx_path_frame_data_i;
      end
    end
  end

  // ---------------- Sink: 64 kHz bit clocks ----------------
  reg  [11:0] line_div_r;
  reg  [11:0] ais_div_r;
  reg         line_tick_r;
  reg         ais_tick_r;
  reg         line_phase_r;
  reg         ais_phase_r;
  wire [11:0] ais_bit_cyc;
  wire [11:0] ais_half_cyc;

  assign ais_bit_cyc  = `GCB_AIS_BIT_CYC;
  assign ais_half_cyc = `GCB_AIS_HALF_CYC;

  always @(posedge core_clk_i) begin
    if (!reset_n_i) begin
      line_div_r   <= 12'h000;
      line_tick_r  <= 1'b0;
      line_phase_r <= 1'b0;
    end else begin
      line_tick_r <= 1'b0;
      if (rx_rise) begin
        if (line_div_r == `GCB_LINE_DIV - 12'h001) begin
          line_div_r  <= 12'h000;
          line_tick_r <= 1'b1;
        end else begin
          line_div_r <= line_div_r + 12'h001;
        end
        line_phase_r <= (line_div_r < `GCB_LINE_HALF);
      end
    end
  end

  // Local bit clock keeps the all-ones signal at rate when the line clock is lost
  always @(posedge core_clk_i) begin
    if (!reset_n_i) begin
      ais_div_r   <= 12'h000;
      ais_tick_r  <= 1'b0;
      ais_phase_r <= 1'b0;
    end else begin
      ais_tick_r <= 1'b0;
      if (ais_div_r == ais_bit_cyc - 12'h001) begin
        ais_div_r  <= 12'h000;
        ais_tick_r <= 1'b1;
      end else begin
        ais_div_r <= ais_div_r + 12'h001;
      end
      ais_phase_r <= (ais_div_r < ais_half_cyc);
    end
  end

  // ---------------- Sink: serialiser and alarm substitution ----------------
  reg        ais_r;
  reg        bit_tick;
  reg        bit_phase;
  reg [7:0]  ser_shift_r;
  reg [2:0]  ser_idx_r;
  reg        snk_data_r;
  reg        snk_clock_r;
  reg        snk_phase_r;
  wire       ais_now;

  assign ais_now = trail_signal_fail_in_i | ~snk_function_activate_i;

  always @* begin
    bit_tick  = ais_r ? ais_tick_r : line_tick_r;
    bit_phase = ais_r ? ais_phase_r : line_phase_r;
  end

  always @(posedge core_clk_i) begin
    if (!reset_n_i) begin
      ais_r       <= 1'b1;
      ser_shift_r <= `GCB_ALL_ONES;
      ser_idx_r   <= 3'h0;
      snk_data_r  <= 1'b1;
      snk_clock_r <= 1'b0;
      snk_phase_r <= 1'b0;
    end else begin
      ais_r       <= ais_now;
      snk_clock_r <= bit_phase;
      if (ais_now) begin
        snk_data_r <= 1'b1;
      end
      if (bit_tick) begin
        ser_idx_r   <= ser_idx_r + 3'h1;
        snk_phase_r <= (ser_idx_r == 3'h0);
        if (ser_idx_r == 3'h0) begin
          ser_shift_r <= {store_r[6:0], 1'b1};
          if (!ais_now) begin
            snk_data_r <= store_r[7];
          end
        end else begin
          ser_shift_r <= {ser_shift_r[6:0], 1'b1};
          if (!ais_now) begin
            snk_data_r <= ser_shift_r[7];
          end
        end
      end
    end
  end

  assign snk_client_data_o         = snk_data_r;
  assign snk_client_clock_o        = snk_clock_r;
  assign snk_octet_phase_o         = snk_phase_r;
  assign alarm_substitute_action_o = ais_r;

endmodule

// File: hdl/gcb_regs.vh
// Constants for the 64 kbit/s general communications byte channel adaptation
//
// Summary of operation
// - Source inserts client octets into overhead byte
// - Client bits written on client clock
// - Read out on path clock, frame, slips
// - Positive slip skips one whole octet once
// - Negative slip reads same octet again
// - Buffer absorbs 18 us wander without errors
// - Source writes byte only while activated
// - Sink extracts overhead byte as 64k channel
// - Sink latches octet on received path clock
// - Shift out on line clock divided 2176
// - Inactive sink drives continuous all-ones
// - Trail fail gives all-ones within 1 ms
// - Fail cleared resumes data within 1 ms
`ifndef GCB_REGS_VH
`define GCB_REGS_VH

`define GCB_OCTET_W        8
`define GCB_BIT_CNT_W      4
`define GCB_OCTET_LAST     4'h8
`define GCB_ALL_ONES       8'hFF

`define GCB_FIFO_DEPTH     32
`define GCB_FIFO_AW        5
`define GCB_LEVEL_W        6
`define GCB_FILL_LOW       6'h02
`define GCB_FILL_HIGH      6'h1E

`define GCB_WANDER_NS      18000
`define GCB_CLIENT_BIT_NS  15625
`define GCB_CLK_PERIOD_NS  5

`define GCB_DIV_W          12
`define GCB_LINE_DIV       12'h880
`define GCB_LINE_HALF      12'h440
// One 64 kbit/s bit is 3125 core cycles of 5 ns; sized to the 12-bit divider
`define GCB_AIS_BIT_CYC    12'hC35
`define GCB_AIS_HALF_CYC   12'h61A
`define GCB_AIS_MAX_NS     1000000

`endif

// File: hdl/gcb_fifo.v
// Slip buffer FIFO with registered read data
`timescale 1ns/1ps
module gcb_fifo #(
  parameter WIDTH = 8,
  parameter DEPTH = 32,
  parameter AW    = 5
) (
  input  wire             core_clk_i,
  input  wire             reset_n_i,
  input  wire [WIDTH-1:0] in_data_i,
  input  wire             in_valid_i,
  output wire             in_ready_o,
  output reg  [WIDTH-1:0] out_data_o,
  output reg              out_valid_o,
  input  wire             out_ready_i,
  output reg  [AW:0]      level_o
);

  reg [WIDTH-1:0] mem_r [0:DEPTH-1];
  reg [AW-1:0]    wr_ptr_r;
  reg [AW-1:0]    rd_ptr_r;
  wire            push;
  wire            pop;
  wire [AW-1:0]   rd_next;

  assign in_ready_o = (level_o != DEPTH[AW:0]);
  assign push       = in_valid_i & in_ready_o;
  assign pop        = out_valid_o & out_ready_i;
  assign rd_next    = pop ? rd_ptr_r + {{(AW-1){1'b0}}, 1'b1} : rd_ptr_r;

  always @(posedge core_clk_i) begin
    if (push) begin
      mem_r[wr_ptr_r] <= in_data_i;
    end
  end

  always @(posedge core_clk_i) begin
    if (!reset_n_i) begin
      wr_ptr_r    <= {AW{1'b0}};
      rd_ptr_r    <= {AW{1'b0}};
      level_o     <= {(AW+1){1'b0}};
      out_valid_o <= 1'b0;
      out_data_o  <= {WIDTH{1'b0}};
    end else begin
      if (push) begin
        wr_ptr_r <= wr_ptr_r + {{(AW-1){1'b0}}, 1'b1};
      end
      rd_ptr_r <= rd_next;
      if (push && !pop) begin
        level_o <= level_o + {{AW{1'b0}}, 1'b1};
      end else if (pop && !push) begin
        level_o <= level_o - {{AW{1'b0}}, 1'b1};
      end
      // Valid drops for one cycle after a pop while the next word is fetched
      out_valid_o <= (level_o != {(AW+1){1'b0}}) & ~pop;
      out_data_o  <= mem_r[rd_next];
    end
  end

endmodule

// File: verif/gcb_top_assertions.sv
// Assertion checker for the overhead byte channel adaptation
`timescale 1ns/1ps
module gcb_top_checker (
  input wire core_clk_i,
  input wire reset_n_i,
  input wire src_function_activate_i,
  input wire path_gc_write_o,
  input wire src_slip_pos_o,
  input wire src_slip_neg_o,
  input wire trail_signal_fail_in_i,
  input wire snk_function_activate_i,
  input wire snk_client_data_o,
  input wire snk_client_clock_o,
  input wire alarm_substitute_action_o
);
  default clocking @(posedge core_clk_i); endclocking
  default disable iff (!reset_n_i);
  reg [12:0] gap_r;
  reg [13:0] run_r;
  // Cycles since the last client clock rise, and length of the current alarm
  always @(posedge core_clk_i) begin
    if (!reset_n_i || $rose(snk_client_clock_o)) begin
      gap_r <= 13'h0000;
    end else if (gap_r != 13'h1FFF) begin
      gap_r <= gap_r + 13'h0001;
    end
    if (!reset_n_i || !alarm_substitute_action_o) begin
      run_r <= 14'h0000;
    end else if (run_r != 14'h3FFF) begin
      run_r <= run_r + 14'h0001;
    end
  end
  sequence s_pos_slip;
    src_slip_pos_o && src_function_activate_i;
  endsequence
  sequence s_late_write;
    ##2 path_gc_write_o;
  endsequence
  chk_write_active: assert property (path_gc_write_o |-> $past(src_function_activate_i))
    else $error("overhead byte written while inactive");
  chk_write_pulse: assert property (path_gc_write_o |=> !path_gc_write_o)
    else $error("write pulse longer than one cycle");
  chk_slip_excl: assert property (!(src_slip_pos_o && src_slip_neg_o))
    else $error("both slip kinds at once");
  chk_pos_skip: assert property (s_pos_slip |-> s_late_write)
    else $error("no write two cycles after positive slip");
  chk_ais_ones: assert property ((trail_signal_fail_in_i || !snk_function_activate_i)
    |=> snk_client_data_o) else $error("client data not forced to ones");
  chk_alarm_track: assert property (1'b1 |=> alarm_substitute_action_o ==
    $past(trail_signal_fail_in_i || !snk_function_activate_i)) else $error("alarm wrong");
  chk_ais_rate: assert property ($rose(snk_client_clock_o) && run_r > 14'h1B58
    |-> gap_r == 13'h0C34) else $error("alarm bit period wrong");
  // Data moves while the clock is low, and the clock rises one or two cycles later
  chk_bit_edge: assert property ($changed(snk_client_data_o)
    && !$rose(alarm_substitute_action_o) |-> !snk_client_clock_o
    ##[1:2] $rose(snk_client_clock_o)) else $error("client data changed mid-bit");
endmodule

bind gcb_top gcb_top_checker u_gcb_top_checker (
  .core_clk_i(core_clk_i), .reset_n_i(reset_n_i),
  .src_function_activate_i(src_function_activate_i), .path_gc_write_o(path_gc_write_o),
  .src_slip_pos_o(src_slip_pos_o), .src_slip_neg_o(src_slip_neg_o),
  .trail_signal_fail_in_i(trail_signal_fail_in_i),
  .snk_function_activate_i(snk_function_activate_i), .snk_client_data_o(snk_client_data_o),
  .snk_client_clock_o(snk_client_clock_o),
  .alarm_substitute_action_o(alarm_substitute_action_o)
);

// File: verif/gcb_far_model.sv
// Far-side model: client channel source, path timing and received line
`timescale 1ns/1ps
module gcb_far_model (
  input  wire       core_clk_i,
  input  wire       reset_n_i,
  input  wire       client_en_i,
  input  wire       frame_en_i,
  input  wire [7:0] frame_gap_i,
  input  wire [7:0] rx_byte_i,
  output reg        client_channel_clock_o,
  output wire       client_channel_data_o,
  output wire       client_octet_phase_o,
  output reg        path_timing_clock_o,
  output reg        path_frame_start_o,
  output reg        rx_path_clock_o,
  output reg        rx_gc_strobe_o,
  output wire [7:0] rx_path_frame_data_o
);
  reg [2:0] cc_r;
  reg [2:0] bit_r;
  reg [7:0] oct_r;
  reg [7:0] fcnt_r;
  reg [2:0] rcnt_r;
  // Idle client line toggles so a stale bit is never read as valid
  assign client_channel_data_o = client_en_i ? oct_r[3'h7 - bit_r] : rx_path_clock_o;
  assign client_octet_phase_o = client_en_i && bit_r == 3'h0;
  assign rx_path_frame_data_o = rx_gc_strobe_o ? rx_byte_i : ~rx_byte_i;
  always @(posedge core_clk_i) begin
    rx_path_clock_o <= reset_n_i & ~rx_path_clock_o;
    if (!reset_n_i) begin
      rcnt_r <= 3'h0;
      rx_gc_strobe_o <= 1'b0;
      oct_r <= 8'h00;
    end else if (!rx_path_clock_o) begin
      rcnt_r <= rcnt_r + 3'h1;
      rx_gc_strobe_o <= rcnt_r == 3'h0;
    end
    if (!reset_n_i || !client_en_i) begin
      cc_r <= 3'h0;
      bit_r <= 3'h0;
      client_channel_clock_o <= 1'b0;
    end else begin
      cc_r <= cc_r + 3'h1;
      if (cc_r == 3'h3) client_channel_clock_o <= 1'b1;
      if (cc_r == 3'h7) begin
        client_channel_clock_o <= 1'b0;
        bit_r <= bit_r + 3'h1;
        if (bit_r == 3'h7) oct_r <= oct_r + 8'h01;
      end
    end
    if (!reset_n_i || !frame_en_i) begin
      path_timing_clock_o <= 1'b0;
      path_frame_start_o <= 1'b0;
      fcnt_r <= 8'h00;
    end else begin
      path_timing_clock_o <= ~path_timing_clock_o;
      path_frame_start_o <= !path_timing_clock_o && fcnt_r == frame_gap_i;
      if (!path_timing_clock_o) fcnt_r <= (fcnt_r == frame_gap_i) ? 8'h00 : fcnt_r + 8'h01;
    end
  end
endmodule

// File: verif/gcb_top_tb_top.sv
// Testbench for the overhead byte channel adaptation
`timescale 1ns/1ps
module gcb_top_tb_top;
  reg         core_clk_i = 1'b0;
  reg         reset_n_i = 1'b0;
  reg         src_act = 1'b1;
  reg         snk_act = 1'b1;
  reg         tsf = 1'b0;
  reg         client_en = 1'b0;
  reg         frame_en = 1'b0;
  reg   [7:0] frame_gap = 8'h0F;
  wire        c_clk, c_dat, c_ph, p_clk, p_fs, r_clk, r_stb;
  wire  [7:0] r_dat, p_dat;
  wire        gc_wr, s_pos, s_neg, k_dat, k_clk, k_ph, alarm;
  integer     n_errors = 0;
  integer     tests_run = 0;
  integer     cycles = 0;
  integer     n_pos = 0;
  integer     n_neg = 0;
  integer     n_wr = 0;
  reg   [7:0] prev_r = 8'hFF;
  reg         sync_r = 1'b1;
  reg         pos_r = 1'b0;
  reg         neg_r = 1'b0;

  gcb_far_model u_gcb_far_model (.core_clk_i(core_clk_i), .reset_n_i(reset_n_i),
    .client_en_i(client_en), .frame_en_i(frame_en), .frame_gap_i(frame_gap),
    .rx_byte_i(8'hA5), .client_channel_clock_o(c_clk), .client_channel_data_o(c_dat),
    .client_octet_phase_o(c_ph), .path_timing_clock_o(p_clk), .path_frame_start_o(p_fs),
    .rx_path_clock_o(r_clk), .rx_gc_strobe_o(r_stb), .rx_path_frame_data_o(r_dat));
  gcb_top u_gcb_top (.core_clk_i(core_clk_i), .reset_n_i(reset_n_i),
    .client_channel_data_i(c_dat), .client_channel_clock_i(c_clk),
    .client_octet_phase_i(c_ph), .path_timing_clock_i(p_clk), .path_frame_start_i(p_fs),
    .src_function_activate_i(src_act), .path_frame_data_o(p_dat), .path_gc_write_o(gc_wr),
    .src_slip_pos_o(s_pos), .src_slip_neg_o(s_neg), .rx_path_frame_data_i(r_dat),
    .rx_path_clock_i(r_clk), .rx_gc_strobe_i(r_stb), .trail_signal_fail_in_i(tsf),
    .snk_function_activate_i(snk_act), .snk_client_data_o(k_dat),
    .snk_client_clock_o(k_clk), .snk_octet_phase_o(k_ph), .alarm_substitute_action_o(alarm));

  always #2.5 core_clk_i = ~core_clk_i;

  task check(input string what, input logic [31:0] exp, input logic [31:0] got);
    tests_run = tests_run + 1;
    if (got !== exp) begin
      n_errors = n_errors + 1;
      $display("CHECK FAILED %s expected %h seen %h", what, exp, got);
    end
  endtask

  task conclude;
    $display("checks %0d mismatches %0d", tests_run, n_errors);
    if (n_errors == 0 && tests_run > 0) $display("== PASSED ==");
    else $display("== FAILED ==");
    $finish;
  endtask

  always @(posedge core_clk_i) begin
    cycles = cycles + 1;
    if (cycles == 100000) begin
      n_errors = n_errors + 1;
      conclude();
    end
  end

  // Each written byte, except the first after the source was inactive, follows the previous one by one, two after a skip, none after a repeat
  always @(posedge core_clk_i) begin
    if (reset_n_i === 1'b1) begin
      if (src_act !== 1'b1) sync_r = 1'b0;
      pos_r = pos_r | s_pos;
      neg_r = neg_r | s_neg;
      n_pos = n_pos + s_pos;
      n_neg = n_neg + s_neg;
      if (gc_wr === 1'b1) begin
        n_wr = n_wr + 1;
        if (sync_r) check("gc byte", neg_r ? prev_r : 8'(prev_r + (pos_r ? 8'h02 : 8'h01)), p_dat);
        prev_r = p_dat;
        sync_r = 1'b1;
        pos_r = 1'b0;
        neg_r = 1'b0;
      end
    end
  end

  task automatic snk_bit(output logic b, output logic ph);
    @(negedge k_clk);
    b = k_dat;
    ph = k_ph;
  endtask

  task automatic bit_time(input integer exp);
    realtime t0;
    @(posedge k_clk);
    t0 = $realtime;
    @(posedge k_clk);
    check("bit period", exp, int'(($realtime - t0) / 5.0));
  endtask

  task automatic t_sink_data;
    logic b, ph;
    logic [7:0] got;
    integer i;
    ph = 1'b0;
    for (i = 0; i < 10 && ph !== 1'b1; i++) snk_bit(b, ph);
    check("octet phase", 1, ph);
    got = {7'h00, b};
    for (i = 0; i < 7; i++) begin
      snk_bit(b, ph);
      got = {got[6:0], b};
    end
    check("sink octet", 8'hA5, got);
    bit_time(4352);
    $display("t_sink_data done");
  endtask

  task automatic t_alarm;
    logic b, ph, z;
    integer i;
    @(posedge core_clk_i) tsf <= 1'b1;
    repeat (3) @(posedge core_clk_i);
    check("alarm", 1, alarm);
    check("ais data", 1, k_dat);
    bit_time(3125);
    bit_time(3125);
    @(posedge core_clk_i) tsf <= 1'b0;
    z = 1'b1;
    for (i = 0; i < 4; i++) begin
      snk_bit(b, ph);
      z = z & b;
    end
    check("data resumed", 0, z);
    check("alarm clear", 0, alarm);
    $display("t_alarm done");
  endtask

  task automatic run_frames(input [7:0] gap, input integer n);
    @(posedge core_clk_i) frame_gap <= gap;
    frame_en <= 1'b1;
    repeat (n) @(posedge core_clk_i);
    frame_en <= 1'b0;
    repeat (8) @(posedge core_clk_i);
  endtask

  task automatic t_src_slips;
    @(posedge core_clk_i) client_en <= 1'b1;
    run_frames(8'h0F, 3000);
    check("neg slips", 1, n_neg > 0);
    run_frames(8'h2F, 9000);
    check("pos slips", 1, n_pos > 0);
    $display("t_src_slips done");
  endtask

  task automatic t_inactive;
    integer w0;
    @(posedge core_clk_i) src_act <= 1'b0;
    snk_act <= 1'b0;
    w0 = n_wr;
    run_frames(8'h2F, 800);
    check("writes off", w0, n_wr);
    check("inactive data", 1, k_dat);
    @(posedge core_clk_i) src_act <= 1'b1;
    snk_act <= 1'b1;
    run_frames(8'h2F, 800);
    check("writes on", 1, n_wr > w0);
    $display("t_inactive done");
  endtask

  initial begin
    repeat (8) @(posedge core_clk_i);
    reset_n_i <= 1'b1;
    @(posedge core_clk_i);
    t_sink_data;
    t_alarm;
    t_src_slips;
    t_inactive;
    conclude();
  end
endmodule
